/* File: rtl/esi_ext_status.sv */
// External/status source control, status byte and frame status queue
//
// What this block does
// - A source interrupts only on conditions arising after its enable was set.
// - Source enables gate interrupts only while the external/status group is enabled; bits 2, 1 (status) and 0 act regardless.
// - Enable bit 7 lets any break/abort change interrupt; reset sets it.
// - Enable bit 6 lets underrun/EOM latch rising edges interrupt; reset sets it.
// - Enable bit 5 lets clear-to-send changes interrupt; reset sets it.
// - Enable bit 4: sync pin change in async and external sync, hunt change otherwise.
// - Enable bit 3 lets carrier-detect changes interrupt; reset sets it.
// - Bit 2 in SDLC queues five status bits and count, ten frames.
// - Enable bit 1 interrupts when baud counter reaches zero; reset clears it.
// - Bit 0 steers register-7 writes to alternate; reads back at fourteen.
// - Status byte is captured at its read strobe in every mode; the MODE_ENH bit is unused.
// - Async break status sets on break, clears when break ends.
// - SDLC abort status follows seven-plus ones; both edges always interrupt.
// - Underrun/EOM set by reset, disable, abort, underrun; rising edge interrupts.
// - In async a send-abort restores underrun/EOM to one and interrupts.
// - Clear-to-send latched while pending if enabled, live when disabled.
// - Crystal option in async holds sync/hunt at zero, no interrupt.
// - Byte sync: enter-hunt sets hunt, sync found clears; pin pulses low.
// - SDLC hunt set by enter-hunt or receiver off, cleared by opening flag.
// - Zero-count status reads one only while counter sits at zero.
`timescale 1ns/10ps
module esi_ext_status
    import esi_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic i_cts_n,
    input wire logic i_carrier_detect_in_n,
    input wire logic i_sync_n,
    output logic o_sync_n,
    output logic o_sync_oe_n,
    input wire esi_rx_ev_t i_rx,
    input wire esi_tx_ev_t i_tx,
    input wire logic i_brg_zero,
    input wire logic i_rx_char_avail,
    input wire logic [FRM_STAT_W-1:0] i_rx_cond_live,
    input wire logic i_frame_end,
    input wire esi_frame_t i_frame,
    output logic o_ext_int,
    output logic [DATA_W-1:0] o_sync_flag_char,
    output logic [DATA_W-1:0] o_alternate_seven
);
    typedef struct packed {
        logic [DATA_W-1:0] src_en;
        logic grp_en;
        logic [MODE_BITS-1:0] mode_bits;
        logic [DATA_W-1:0] seven;
        logic [DATA_W-1:0] alt7;
        logic pend;
        logic brk;
        logic und;
        logic hunt;
        logic [2:0] lat;
        logic [2:0] prev;
        logic zc_prev;
        logic zc_wait;
        logic [DATA_W-1:0] rdata;
        logic sync_n;
        logic sync_oe_n;
        logic irq;
    } esi_top_st_t;

    esi_top_st_t s_q;
    esi_top_st_t s_d;

    logic [2:0] pin_s;
    logic fifo_valid;
    esi_frame_t fifo_head;
    logic fifo_active;
    logic fifo_push;
    logic fifo_pop;
    logic fifo_flush;
    logic chan_reset;

    generate
        if (DEPTH < 2) begin : g_bad_depth
            $error("esi_ext_status: DEPTH must be at least 2");
        end
    endgenerate

    // Pins: [2] clear-to-send, [1] sync, [0] carrier detect
    esi_pin_sync #(
        .W(3)
    ) u_pin_sync (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_d({i_cts_n, i_sync_n, i_carrier_detect_in_n}),
        .o_q(pin_s)
    );

    assign fifo_active = s_q.src_en[SRC_FIFO] && (esi_mode_t'(s_q.mode_bits[1:0]) == ESI_SDLC);
    assign chan_reset = i_wr && (i_addr == WR_CMD)
        && (esi_cmd_t'(i_wdata[CMD_LSB +: 3]) == ESI_CMD_CHAN_RESET);
    assign fifo_push = i_frame_end && fifo_active;
    assign fifo_pop = i_rd && (i_addr == RD_FCNT_HI) && fifo_active && fifo_valid;
    assign fifo_flush = !fifo_active || chan_reset;

    esi_status_fifo #(
        .DEPTH(DEPTH)
    ) u_status_fifo (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_flush(fifo_flush),
        .i_push(fifo_push),
        .i_entry(i_frame),
        .i_pop(fifo_pop),
        .o_valid(fifo_valid),
        .o_head(fifo_head)
    );

    always_comb begin
        esi_mode_t mode;
        esi_cmd_t cmd;
        logic wr_cmd;
        logic rst_ext;
        logic send_abort;
        logic enter_hunt;
        logic rst_und;
        logic [2:0] live;
        logic [2:0] ie3;
        logic [2:0] shown;
        logic hunt_live;
        logic und_rise;
        logic zc_rise;
        logic ev_open;
        logic ev_brk;
        logic zc_retrig;
        logic open_latch;
        logic [DATA_W-1:0] status;
        mode = esi_mode_t'(s_q.mode_bits[MODE_LSB +: 2]);
        cmd = esi_cmd_t'(i_wdata[CMD_LSB +: 3]);
        wr_cmd = i_wr && (i_addr == WR_CMD);
        rst_ext = wr_cmd && (cmd == ESI_CMD_RST_EXT);
        send_abort = wr_cmd && (cmd == ESI_CMD_SEND_ABORT);
        enter_hunt = wr_cmd && (cmd == ESI_CMD_ENTER_HUNT);
        rst_und = wr_cmd && (cmd == ESI_CMD_RST_UNDERRUN);
        s_d = s_q;

        // Break/abort source
        case (mode)
            ESI_ASYNC: begin
                if (i_rx.break_det) begin
                    s_d.brk = 1'b1;
                end else if (i_rx.break_end) begin
                    s_d.brk = 1'b0;
                end
            end
            ESI_SDLC: begin
                s_d.brk = i_rx.abort_ones;
            end
            default: begin
                s_d.brk = 1'b0;
            end
        endcase

        // Underrun/EOM latch: set wins over the reset command
        if (i_tx.tx_disable || i_tx.underrun || send_abort || chan_reset) begin
            s_d.und = 1'b1;
        end else if (rst_und) begin
            s_d.und = 1'b0;
        end
        und_rise = s_d.und && !s_q.und;

        // Hunt state of the receiver
        case (mode)
            ESI_BYTESYNC: begin
                if (enter_hunt || chan_reset) begin
                    s_d.hunt = 1'b1;
                end else if (i_rx.sync_found) begin
                    s_d.hunt = 1'b0;
                end
            end
            ESI_SDLC: begin
                if (enter_hunt || chan_reset || !i_rx.rx_enable) begin
                    s_d.hunt = 1'b1;
                end else if (i_rx.open_flag) begin
                    s_d.hunt = 1'b0;
                end
            end
            default: begin
                if (enter_hunt || chan_reset) begin
                    s_d.hunt = 1'b1;
                end
            end
        endcase

        // Sync/hunt source seen by the status byte
        case (mode)
            ESI_ASYNC: hunt_live = s_q.mode_bits[MODE_CRYSTAL_OSC_OPTION] ? 1'b0 : !pin_s[1];
            ESI_EXTSYNC: hunt_live = !pin_s[1];
            default: hunt_live = s_d.hunt;
        endcase

        // Live conditions, asserted = 1
        live = {!pin_s[2], hunt_live, !pin_s[0]};
        ie3 = {s_q.src_en[SRC_CTS], s_q.src_en[SRC_HUNT], s_q.src_en[SRC_DCD]};
        zc_rise = i_brg_zero && !s_q.zc_prev;

        // Edges against last cycle's value, so a standing condition never fires
        // when its enable is turned on
        open_latch = !s_q.pend || rst_ext;
        ev_open = s_q.grp_en && open_latch && (
            |(ie3 & (live ^ s_q.prev))
            || (s_q.src_en[SRC_UND] && und_rise)
            || (s_q.src_en[SRC_ZC] && zc_rise));
        // Break/abort edges may be short lived, so they fire even when pending
        ev_brk = s_q.grp_en && s_q.src_en[SRC_BRK] && (s_d.brk != s_q.brk);
        // Zero count that arrived while pending fires at service end if the counter is still at zero
        zc_retrig = rst_ext && s_q.zc_wait && i_brg_zero && s_q.src_en[SRC_ZC] && s_q.grp_en;

        if (s_q.grp_en && s_q.src_en[SRC_ZC] && zc_rise && !open_latch) begin
            s_d.zc_wait = 1'b1;
        end else if (rst_ext) begin
            s_d.zc_wait = 1'b0;
        end
        s_d.pend = (s_q.pend && !rst_ext) || ev_open || ev_brk || zc_retrig;
        s_d.lat = open_latch ? live : s_q.lat;
        s_d.prev = live;
        s_d.zc_prev = i_brg_zero;

        // Register writes
        if (i_wr) begin
            case (i_addr)
                WR_GRP_EN: s_d.grp_en = i_wdata[GRP_EXT_BIT];
                WR_MODE: s_d.mode_bits = i_wdata[MODE_BITS-1:0];
                WR_SRC_EN: begin
                    s_d.src_en = i_wdata;
                    if (i_wdata[SRC_ZC] && !s_q.src_en[SRC_ZC]) begin
                        s_d.zc_wait = 1'b0;
                    end
                end
                WR_SEVEN: begin
                    if (s_q.src_en[SRC_PTR]) begin
                        s_d.alt7 = i_wdata;
                    end else begin
                        s_d.seven = i_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        if (chan_reset) begin
            s_d.src_en = SRC_EN_RST;
            s_d.pend = 1'b0;
            s_d.zc_wait = 1'b0;
            s_d.lat = live;
        end

        // Status byte; enabled pins show the latch, others the live level
        shown = (ie3 & s_q.lat) | (~ie3 & live);
        status = {s_q.brk, s_q.und, shown[2], shown[1], shown[0], i_tx.tx_empty,
            s_q.src_en[SRC_ZC] && i_brg_zero, i_rx_char_avail};

        // Read data stand for one cycle only
        s_d.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                // One-strobe read: the byte is captured at the strobe and held
                // in the output flop, so it cannot change mid access
                RD_STATUS: s_d.rdata = status;
                RD_RX_COND: begin
                    if (fifo_active && fifo_valid) begin
                        s_d.rdata = {3'h0, fifo_head.status};
                    end else begin
                        s_d.rdata = {3'h0, i_rx_cond_live};
                    end
                end
                RD_FCNT_LO: begin
                    if (fifo_active && fifo_valid) begin
                        s_d.rdata = fifo_head.count[7:0];
                    end
                end
                RD_FCNT_HI: begin
                    if (fifo_active && fifo_valid) begin
                        s_d.rdata = {2'h0, fifo_head.count[FRM_CNT_W-1:8]};
                    end
                end
                RD_READBACK14: begin
                    if (s_q.mode_bits[MODE_EXTRD]) begin
                        s_d.rdata = s_q.alt7;
                    end
                end
                default: begin
                end
            endcase
        end

        // Sync pin is an output only in byte sync receive
        if (mode == ESI_BYTESYNC) begin
            s_d.sync_oe_n = 1'b0;
            s_d.sync_n = !i_rx.sync_pattern;
        end else begin
            s_d.sync_oe_n = 1'b1;
            s_d.sync_n = 1'b1;
        end
        s_d.irq = s_d.pend && s_d.grp_en;
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= '0;
            s_q.src_en <= SRC_EN_RST;
            s_q.mode_bits <= MODE_RST;
            s_q.und <= 1'b1;
            s_q.hunt <= 1'b1;
            s_q.sync_n <= 1'b1;
            s_q.sync_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_sync_n = s_q.sync_n;
    assign o_sync_oe_n = s_q.sync_oe_n;
    assign o_ext_int = s_q.irq;
    assign o_sync_flag_char = s_q.seven;
    assign o_alternate_seven = s_q.alt7;
endmodule : esi_ext_status

/* File: rtl/esi_pin_sync.sv */
// Two-flop synchroniser for the modem and sync pins
`timescale 1ns/10ps
module esi_pin_sync #(
    parameter int W = 3
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } esi_sync_st_t;

    esi_sync_st_t s_q;
    esi_sync_st_t s_d;

    generate
        if (W < 1) begin : g_bad_w
            $error("esi_pin_sync: W must be at least 1");
        end
    endgenerate

    always_comb begin
        s_d.meta = i_d;
        s_d.stab = s_q.meta;
    end

    // Pins idle high (inactive), so reset to ones avoids a false first edge
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_q = s_q.stab;
endmodule : esi_pin_sync

/* File: rtl/esi_pkg.sv */
// Shared constants and types for the external/status interrupt source block
package esi_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Write addresses
    localparam logic [ADDR_W-1:0] WR_CMD = 4'h0;
    localparam logic [ADDR_W-1:0] WR_GRP_EN = 4'h1;
    localparam logic [ADDR_W-1:0] WR_MODE = 4'h2;
    localparam logic [ADDR_W-1:0] WR_SEVEN = 4'h7;
    localparam logic [ADDR_W-1:0] WR_SRC_EN = 4'hf;

    // Read addresses
    localparam logic [ADDR_W-1:0] RD_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] RD_RX_COND = 4'h1;
    localparam logic [ADDR_W-1:0] RD_FCNT_LO = 4'h6;
    localparam logic [ADDR_W-1:0] RD_FCNT_HI = 4'h7;
    localparam logic [ADDR_W-1:0] RD_READBACK14 = 4'he;

    // Source enable / status byte bit positions
    localparam int SRC_BRK = 7;
    localparam int SRC_UND = 6;
    localparam int SRC_CTS = 5;
    localparam int SRC_HUNT = 4;
    localparam int SRC_DCD = 3;
    localparam int SRC_FIFO = 2;
    localparam int SRC_ZC = 1;
    localparam int SRC_PTR = 0;
    localparam logic [DATA_W-1:0] SRC_EN_RST = 8'hf8;

    // Group enable, mode and command fields
    localparam int GRP_EXT_BIT = 0;
    localparam int MODE_LSB = 0;
    localparam int MODE_CRYSTAL_OSC_OPTION = 2;
    localparam int MODE_EXTRD = 3;
    localparam int MODE_ENH = 4;
    localparam int MODE_BITS = 5;
    localparam logic [MODE_BITS-1:0] MODE_RST = 5'h00;
    localparam int CMD_LSB = 0;

    // Frame status queue
    localparam int FRM_STAT_W = 5;
    localparam int FRM_CNT_W = 14;
    localparam int FIFO_DEPTH = 10;

    typedef enum logic [1:0] {
        ESI_ASYNC,
        ESI_EXTSYNC,
        ESI_BYTESYNC,
        ESI_SDLC
    } esi_mode_t;

    typedef enum logic [2:0] {
        ESI_CMD_NULL,
        ESI_CMD_RST_EXT,
        ESI_CMD_SEND_ABORT,
        ESI_CMD_ENTER_HUNT,
        ESI_CMD_RST_UNDERRUN,
        ESI_CMD_CHAN_RESET,
        ESI_CMD_RSV6,
        ESI_CMD_RSV7
    } esi_cmd_t;

    typedef struct packed {
        logic [FRM_STAT_W-1:0] status;
        logic [FRM_CNT_W-1:0] count;
    } esi_frame_t;

    typedef struct packed {
        logic break_det;
        logic break_end;
        logic abort_ones;
        logic sync_found;
        logic sync_pattern;
        logic open_flag;
        logic rx_enable;
    } esi_rx_ev_t;

    typedef struct packed {
        logic underrun;
        logic tx_disable;
        logic tx_empty;
    } esi_tx_ev_t;

endpackage : esi_pkg

/* File: rtl/esi_status_fifo.sv */
// Per-frame status and byte count queue
`timescale 1ns/10ps
module esi_status_fifo
    import esi_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_flush,
    input wire logic i_push,
    input wire esi_frame_t i_entry,
    input wire logic i_pop,
    output logic o_valid,
    output esi_frame_t o_head
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        esi_frame_t [DEPTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
    } esi_fifo_st_t;

    esi_fifo_st_t s_q;
    esi_fifo_st_t s_d;

    generate
        if (DEPTH < 2) begin : g_bad_depth
            $error("esi_status_fifo: DEPTH must be at least 2");
        end
    endgenerate

    function automatic logic [PW-1:0] esi_wrap_inc(input logic [PW-1:0] p);
        esi_wrap_inc = (p == LAST) ? '0 : p + 1'b1;
    endfunction : esi_wrap_inc

    always_comb begin
        logic do_push;
        logic do_pop;
        do_pop = i_pop && (s_q.cnt != '0);
        // A full queue drops the newest frame rather than overwrite the oldest
        do_push = i_push && ((s_q.cnt != FULL) || do_pop);
        s_d = s_q;
        if (do_push) begin
            s_d.mem[s_q.wr] = i_entry;
            s_d.wr = esi_wrap_inc(s_q.wr);
        end
        if (do_pop) begin
            s_d.rd = esi_wrap_inc(s_q.rd);
        end
        if (do_push && !do_pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        if (i_flush) begin
            s_d.wr = '0;
            s_d.rd = '0;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_valid = (s_q.cnt != '0);
    assign o_head = s_q.mem[s_q.rd];
endmodule : esi_status_fifo

/* File: test/esi_ext_status_assertions.sv */
// Port-level checker for the external/status source block
`timescale 1ns/10ps
module esi_ext_status_chk
    import esi_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic i_cts_n,
    input wire logic i_carrier_detect_in_n,
    input wire logic o_sync_n,
    input wire logic o_sync_oe_n,
    input wire logic i_brg_zero,
    input wire logic o_ext_int
);
    logic [DATA_W-1:0] src_q;
    logic grp_q;
    // Shadow of the enables, so edge checks know what is armed
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            src_q <= SRC_EN_RST;
            grp_q <= 1'b0;
        end else if (i_wr && i_addr == WR_SRC_EN) begin
            src_q <= i_wdata;
        end else if (i_wr && i_addr == WR_CMD && i_wdata[2:0] == 3'h5) begin
            src_q <= SRC_EN_RST;
        end else if (i_wr && i_addr == WR_GRP_EN) begin
            grp_q <= i_wdata[GRP_EXT_BIT];
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data present without a read");
    unmapped_rd_a: assert property (i_rd && i_addr inside {4'h3, 4'h5, 4'h8} |=> o_rdata == 8'h00)
        else $error("unmapped read returned data");
    grp_gate_a: assert property (!grp_q [*2] |-> !o_ext_int)
        else $error("interrupt with group disabled");
    cts_edge_a: assert property ($changed(i_cts_n) ##2 (grp_q && src_q[SRC_CTS]
        && !o_ext_int) |=> o_ext_int)
        else $error("clear-to-send change not signalled");
    dcd_edge_a: assert property ($changed(i_carrier_detect_in_n)
        ##2 (grp_q && src_q[SRC_DCD] && !o_ext_int) |=> o_ext_int)
        else $error("carrier change not signalled");
    zero_cnt_a: assert property ($rose(i_brg_zero) && grp_q && src_q[SRC_ZC]
        && !o_ext_int |=> o_ext_int)
        else $error("zero count not signalled");
    sync_pulse_a: assert property ($fell(o_sync_n) |=> o_sync_n)
        else $error("sync pulse longer than one cycle");
    sync_drive_a: assert property (!o_sync_n |-> !o_sync_oe_n)
        else $error("sync low while not driven");
endmodule : esi_ext_status_chk

bind esi_ext_status esi_ext_status_chk #(.DEPTH(DEPTH)) i_chk (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cts_n(i_cts_n),
    .i_carrier_detect_in_n(i_carrier_detect_in_n), .o_sync_n(o_sync_n),
    .o_sync_oe_n(o_sync_oe_n), .i_brg_zero(i_brg_zero), .o_ext_int(o_ext_int));

/* File: test/esi_line_model.sv */
// Modem lines and external sync logic on the far side of the pins
`timescale 1ns/10ps
module esi_line_model (
    input wire logic i_cts_on,
    input wire logic i_dcd_on,
    input wire logic i_sync_on,
    input wire logic i_sync_n,
    input wire logic i_sync_oe_n,
    output logic o_cts_n,
    output logic o_dcd_n,
    output logic o_sync_n
);
    assign o_cts_n = !i_cts_on;
    assign o_dcd_n = !i_dcd_on;
    // Sync logic holds the wire high until in step; device wins when driving
    assign o_sync_n = !i_sync_oe_n ? i_sync_n : !i_sync_on;
endmodule : esi_line_model

/* File: test/tb.sv */
// Self-checking bench for the external/status source block
`timescale 1ns/10ps
module tb
    import esi_pkg::*;
;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata, o_sync_flag_char, o_alternate_seven, a, b;
    logic cts_on = 1'b0, dcd_on = 1'b0, sync_on = 1'b0, rd_pend = 1'b0;
    logic cts_n, dcd_n, sync_pin_n, o_sync_n, o_sync_oe_n, o_ext_int;
    logic i_brg_zero = 1'b0, i_rx_char_avail = 1'b0, i_frame_end = 1'b0;
    logic [FRM_STAT_W-1:0] i_rx_cond_live = '0;
    // Receiver left on: SDLC keeps hunting while it is off
    esi_rx_ev_t i_rx = esi_rx_ev_t'(7'h01);
    esi_tx_ev_t i_tx = '0;
    esi_frame_t i_frame = '0, fr;
    logic [15:0] exp_q[$];
    int seed, k, miscompares = 0, samples_checked = 0;

    initial begin
        forever #2.5 i_clock = !i_clock;
    end

    esi_ext_status i_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cts_n(cts_n),
        .i_carrier_detect_in_n(dcd_n), .i_sync_n(sync_pin_n), .o_sync_n(o_sync_n),
        .o_sync_oe_n(o_sync_oe_n), .i_rx(i_rx), .i_tx(i_tx), .i_brg_zero(i_brg_zero),
        .i_rx_char_avail(i_rx_char_avail), .i_rx_cond_live(i_rx_cond_live),
        .i_frame_end(i_frame_end), .i_frame(i_frame), .o_ext_int(o_ext_int),
        .o_sync_flag_char(o_sync_flag_char), .o_alternate_seven(o_alternate_seven));

    esi_line_model i_line (.i_cts_on(cts_on), .i_dcd_on(dcd_on), .i_sync_on(sync_on),
        .i_sync_n(o_sync_n), .i_sync_oe_n(o_sync_oe_n), .o_cts_n(cts_n), .o_dcd_n(dcd_n),
        .o_sync_n(sync_pin_n));

    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask : check

    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= ad;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr

    // Expected value and mask are queued for the watcher below
    task automatic rd(input logic [3:0] ad, input logic [7:0] e, input logic [7:0] m);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= ad;
        exp_q.push_back({e, m});
        @(posedge i_clock);
        i_rd <= 1'b0;
    endtask : rd

    // Quiet wait first when no interrupt is expected, so a late one is seen
    task automatic want_int(input logic e);
        int n;
        if (!e) repeat (8) @(posedge i_clock);
        for (n = 0; n < 10 && o_ext_int !== e; n++) @(posedge i_clock);
        check(o_ext_int, e);
        if (n == 10) give_verdict();
    endtask : want_int

    task automatic clr();
        wr(WR_CMD, 8'h01);
        repeat (3) @(posedge i_clock);
        check(o_ext_int, 1'b0);
    endtask : clr

    always @(posedge i_clock) begin
        if (rd_pend) begin
            check(o_rdata & exp_q[0][7:0], exp_q[0][15:8]);
            void'(exp_q.pop_front());
        end
        rd_pend <= i_rd;
    end

    initial begin
        #400000;
        miscompares++;
        give_verdict();
    end

    initial begin
        seed = 12;
        a = 8'($random(seed));
        i_rx_char_avail <= a[0];
        i_tx.tx_empty <= a[1];
        i_rx_cond_live <= a[6:2];
        repeat (20) @(posedge i_clock);
        i_rstn <= 1'b1;
        rd(RD_STATUS, {5'b01000, a[1], 1'b0, a[0]}, 8'hff);
        rd(4'h3, 8'h00, 8'hff);
        rd(RD_READBACK14, 8'h00, 8'hff);
        a = 8'($random(seed));
        b = 8'($random(seed));
        wr(WR_SRC_EN, 8'hf9);
        wr(WR_SEVEN, a);
        wr(WR_MODE, 8'h08);
        rd(RD_READBACK14, a, 8'hff);
        wr(WR_SRC_EN, 8'hd8);
        wr(WR_SEVEN, b);
        @(posedge i_clock);
        check({o_alternate_seven, o_sync_flag_char}, {a, b});
        cts_on <= 1'b1;
        dcd_on <= 1'b1;
        want_int(1'b0);
        // Carrier drops now: settled before the group opens, still latched for the read
        dcd_on <= 1'b0;
        rd(RD_STATUS, 8'h28, 8'h28);
        wr(WR_GRP_EN, 8'h01);
        wr(WR_SRC_EN, 8'hf8);
        want_int(1'b0);
        cts_on <= 1'b0;
        want_int(1'b1);
        dcd_on <= 1'b1;
        repeat (6) @(posedge i_clock);
        rd(RD_STATUS, 8'h00, 8'h28);
        dcd_on <= 1'b0;
        repeat (6) @(posedge i_clock);
        clr();
        dcd_on <= 1'b1;
        want_int(1'b1);
        rd(RD_STATUS, 8'h08, 8'h08);
        clr();
        dcd_on <= 1'b0;
        want_int(1'b1);
        clr();
        wr(WR_SRC_EN, 8'hfa);
        i_brg_zero <= 1'b1;
        want_int(1'b1);
        rd(RD_STATUS, 8'h02, 8'h02);
        i_brg_zero <= 1'b0;
        repeat (3) @(posedge i_clock);
        rd(RD_STATUS, 8'h00, 8'h02);
        clr();
        wr(WR_SRC_EN, 8'hf8);
        wr(WR_CMD, 8'h04);
        want_int(1'b0);
        rd(RD_STATUS, 8'h00, 8'h40);
        wr(WR_CMD, 8'h02);
        want_int(1'b1);
        rd(RD_STATUS, 8'h40, 8'h40);
        clr();
        wr(WR_CMD, 8'h04);
        i_tx.underrun <= 1'b1;
        @(posedge i_clock);
        i_tx.underrun <= 1'b0;
        want_int(1'b1);
        clr();
        i_rx.break_det <= 1'b1;
        @(posedge i_clock);
        i_rx.break_det <= 1'b0;
        want_int(1'b1);
        rd(RD_STATUS, 8'h80, 8'h80);
        i_rx.break_end <= 1'b1;
        @(posedge i_clock);
        i_rx.break_end <= 1'b0;
        repeat (3) @(posedge i_clock);
        rd(RD_STATUS, 8'h00, 8'h80);
        clr();
        wr(WR_MODE, 8'h0c);
        sync_on <= 1'b1;
        want_int(1'b0);
        rd(RD_STATUS, 8'h00, 8'h10);
        sync_on <= 1'b0;
        repeat (6) @(posedge i_clock);
        wr(WR_MODE, 8'h08);
        sync_on <= 1'b1;
        want_int(1'b1);
        rd(RD_STATUS, 8'h10, 8'h10);
        clr();
        wr(WR_MODE, 8'h09);
        sync_on <= 1'b0;
        want_int(1'b1);
        clr();
        // Mode switch may itself flag a change; settle it first
        wr(WR_MODE, 8'h0a);
        repeat (6) @(posedge i_clock);
        clr();
        i_rx.sync_found <= 1'b1;
        @(posedge i_clock);
        i_rx.sync_found <= 1'b0;
        want_int(1'b1);
        rd(RD_STATUS, 8'h00, 8'h10);
        clr();
        wr(WR_CMD, 8'h03);
        want_int(1'b1);
        rd(RD_STATUS, 8'h10, 8'h10);
        clr();
        k = 0;
        i_rx.sync_pattern <= 1'b1;
        @(posedge i_clock);
        i_rx.sync_pattern <= 1'b0;
        repeat (4) begin
            @(posedge i_clock);
            if (o_sync_n === 1'b0) k++;
        end
        check({o_sync_oe_n, k[1:0]}, {1'b0, 2'd1});
        wr(WR_MODE, 8'h0b);
        repeat (6) @(posedge i_clock);
        clr();
        i_rx.open_flag <= 1'b1;
        @(posedge i_clock);
        i_rx.open_flag <= 1'b0;
        want_int(1'b1);
        rd(RD_STATUS, 8'h00, 8'h10);
        clr();
        i_rx.abort_ones <= 1'b1;
        want_int(1'b1);
        rd(RD_STATUS, 8'h80, 8'h80);
        i_rx.abort_ones <= 1'b0;
        repeat (3) @(posedge i_clock);
        rd(RD_STATUS, 8'h00, 8'h80);
        clr();
        wr(WR_SRC_EN, 8'hfc);
        fr = esi_frame_t'(19'($random(seed)));
        i_frame <= fr;
        i_frame_end <= 1'b1;
        @(posedge i_clock);
        i_frame_end <= 1'b0;
        rd(RD_RX_COND, {3'b000, fr.status}, 8'h1f);
        rd(RD_FCNT_LO, fr.count[7:0], 8'hff);
        rd(RD_FCNT_HI, {2'b00, fr.count[13:8]}, 8'hff);
        wr(WR_CMD, 8'h03);
        want_int(1'b1);
        clr();
        wr(WR_SRC_EN, 8'h00);
        wr(WR_CMD, 8'h05);
        repeat (3) @(posedge i_clock);
        cts_on <= 1'b1;
        want_int(1'b1);
        repeat (3) @(posedge i_clock);
        give_verdict();
    end
endmodule : tb
